// >>> hdl/stm_pkg.sv
package stm_pkg;

    // ************************************************************
    // Register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [5:0] IDX_CONTROL_A_REGISTER = 6'h00;
    localparam logic [5:0] IDX_CTRLB = 6'h01;
    localparam logic [5:0] IDX_CONTROL_D_REGISTER = 6'h03;
    localparam logic [5:0] IDX_CONTROL_E_SET_REGISTER = 6'h05;
    localparam logic [5:0] IDX_EVENT_CONTROL_REGISTER = 6'h09;
    localparam logic [5:0] IDX_INTERRUPT_ENABLE_REGISTER = 6'h0a;
    localparam logic [5:0] IDX_INTERRUPT_FLAG_REGISTER = 6'h0b;
    localparam logic [5:0] IDX_CNTL = 6'h20;
    localparam logic [5:0] IDX_CNTH = 6'h21;
    localparam logic [5:0] IDX_PERL = 6'h26;
    localparam logic [5:0] IDX_PERH = 6'h27;
    localparam logic [5:0] IDX_CMP0L = 6'h28;
    localparam logic [5:0] IDX_CMP2H = 6'h2d;

    // ************************************************************
    // Field positions and encodings
    // ************************************************************
    localparam int unsigned CONTROL_A_REGISTER_EN_BIT = 0;
    localparam int unsigned CONTROL_A_REGISTER_CLOCK_SELECT_FIELD_LSB = 1;
    localparam int unsigned CTRLB_CMPEN_LSB = 4;
    localparam int unsigned CONTROL_D_REGISTER_SPLIT_BIT = 0;
    localparam int unsigned CTRLE_CMD_LSB = 2;
    localparam int unsigned EVENT_CONTROL_REGISTER_COUNT_ON_EVENT_ENABLE_BIT = 0;
    localparam int unsigned EVENT_CONTROL_REGISTER_EVENT_ACTION_FIELD_LSB = 1;
    localparam logic [1:0] CMD_RESET = 2'h3;
    localparam logic [2:0] WG_SINGLE_SLOPE_SETTING = 3'h3;
    localparam logic [2:0] EVENT_ACTION_FIELD_POSEDGE = 3'h0;
    localparam logic [2:0] EVENT_ACTION_FIELD_ANYEDGE = 3'h1;
    localparam logic [2:0] EVENT_ACTION_FIELD_HIGH = 3'h2;
    localparam logic [2:0] EVENT_ACTION_FIELD_UPDOWN = 3'h3;

    // Flag and enable bit positions, shared by both modes.
    localparam int unsigned FLG_OVF = 0;
    localparam int unsigned FLG_HIGH_UNDERFLOW_SOURCE = 1;
    localparam int unsigned FLG_COMPARE_CHANNEL_ZERO = 4;

    // ************************************************************
    // Reset values and bus answers
    // ************************************************************
    localparam logic [15:0] PER_RESET = 16'hffff;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Prescaler masks for the eight clock-select codes.
    localparam logic [9:0] PRESC_MASK [0:7] = '{10'h000, 10'h001, 10'h003, 10'h007,
                                                10'h00f, 10'h03f, 10'h0ff, 10'h3ff};

endpackage

// >>> hdl/stm_tick_if.sv
`timescale 1ns/1ps
interface stm_tick_if;
    logic run;
    logic [2:0] sel;
    logic tick;
    modport timer (output run, output sel, input tick);
    modport presc (input run, input sel, output tick);
endinterface

// >>> hdl/stm_prescaler.sv
`timescale 1ns/1ps
module stm_prescaler (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Tick towards the timer
    stm_tick_if.presc tk
);

    typedef struct packed {
        logic [9:0] cnt;
        logic tick;
    } stm_presc_t;

    stm_presc_t q;
    stm_presc_t d;
    logic [9:0] mask;

    // ************************************************************
    // Division
    // ************************************************************
    // The divider stays cleared while the timer is off, so the first
    // period after enabling is always a full one.
    always_comb begin
        mask = stm_pkg::PRESC_MASK[tk.sel];
        d = q;
        d.cnt = tk.run ? q.cnt + 10'h001 : 10'h000;
        d.tick = tk.run && ((q.cnt & mask) == mask);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tk.tick = q.tick;

endmodule

// >>> hdl/stm_top.sv
`timescale 1ns/1ps
// Summary of operation
// - Split mode runs two independent 8-bit counters, both counting down only.
// - Split mode supports only single-slope PWM waveform generation.
// - Split mode adds a high-byte underflow interrupt; low byte behaves as usual.
// - High-byte compares raise no compare flag or interrupt in split mode.
// - Event inputs are ignored in split mode.
// - Buffer registers and their valid flags have no effect in split mode.
// - Split mode registers are reached as single bytes, no 16-bit pairing.
// - Mode change reinterprets bits but keeps stored values.
// - Overflow event pulses one clock on overflow, or low underflow in split.
// - High underflow event pulses one clock, only in split mode.
// - Compare events pulse one clock on full match, or low-byte match in split.
// - Each event fires under exactly the conditions setting its interrupt flag.
// - Synchronised event input counts on rising edge, any edge, or while high.
// - Event level may set direction: up while low, down while high.
// - Event action field selects action; input acts only with count-on-event set.
// - Normal mode overflow at top or bottom; compare interrupts on match.
// - Split mode underflow conditions when low or high counter reaches zero.
// - Split compare interrupts match low counter against compare low bytes.
// - Every condition sets its flag; each source gated by its enable bit.
// - Interrupt request stays asserted while a flag is set and enabled.
// - Counting and outputs continue during idle sleep.
// - Split mode gives two 8-bit timers with three compare channels each.
// - Split PWM output clears at zero and sets on its compare match.
// - Hard reset command restores all registers, accepted only while disabled.
// - Clock select divides by 1,2,4,8,16,64,256,1024 for codes 0 to 7.
module stm_top (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // AXI4-Lite write channels
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read channels
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Event input and event outputs
    input wire logic EVENT_IN,
    output logic EV_OVERFLOW_LOW_UNDERFLOW_EVENT,
    output logic EV_HIGH_UNDERFLOW_SOURCE,
    output logic [2:0] EV_CMP,
    // Waveform outputs and interrupt
    output logic [5:0] WO,
    output logic IRQ
);

    typedef struct packed {
        logic en;
        logic [2:0] clock_select_field;
        logic [6:0] ctrlb;
        logic split;
        logic [3:0] event_control_register;
        logic [6:0] inten;
        logic [6:0] flags;
        logic [15:0] cnt;
        logic [15:0] per;
        logic [2:0][15:0] cmp;
        logic [5:0] wo;
        logic [5:0] pin;
        logic [4:0] ev;
        logic irq;
        logic ev_s1;
        logic ev_s2;
        logic ev_prev;
        logic awready;
        logic wready;
        logic aw_have;
        logic w_have;
        logic [7:0] awaddr;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } stm_state_t;

    stm_state_t q;
    stm_state_t d;
    stm_tick_if tk ();

    logic step;
    logic down;
    logic ev_rise;
    logic ev_any;
    logic wg_ss;
    logic hard_rst;
    logic cnt_wr;
    logic [2:0] event_action_field;
    logic [6:0] set;
    logic [6:0] w1c;
    logic [5:0] widx;
    logic [5:0] coff;
    logic [8:0] rd;
    logic [8:0] wr_chk;

    // Returns the byte at an index with an error bit on top.
    function automatic logic [8:0] rd_reg(input logic [5:0] idx, input stm_state_t s);
        logic [5:0] off;
        off = idx - stm_pkg::IDX_CMP0L;
        case (idx)
            stm_pkg::IDX_CONTROL_A_REGISTER: rd_reg = {1'b0, 4'h0, s.clock_select_field, s.en};
            stm_pkg::IDX_CTRLB: rd_reg = {1'b0, 1'b0, s.ctrlb};
            stm_pkg::IDX_CONTROL_D_REGISTER: rd_reg = {1'b0, 7'h00, s.split};
            stm_pkg::IDX_CONTROL_E_SET_REGISTER: rd_reg = 9'h000;
            stm_pkg::IDX_EVENT_CONTROL_REGISTER: rd_reg = {1'b0, 4'h0, s.event_control_register};
            stm_pkg::IDX_INTERRUPT_ENABLE_REGISTER: rd_reg = {1'b0, 1'b0, s.inten};
            stm_pkg::IDX_INTERRUPT_FLAG_REGISTER: rd_reg = {1'b0, 1'b0, s.flags};
            stm_pkg::IDX_CNTL: rd_reg = {1'b0, s.cnt[7:0]};
            stm_pkg::IDX_CNTH: rd_reg = {1'b0, s.cnt[15:8]};
            stm_pkg::IDX_PERL: rd_reg = {1'b0, s.per[7:0]};
            stm_pkg::IDX_PERH: rd_reg = {1'b0, s.per[15:8]};
            default: begin
                if (idx >= stm_pkg::IDX_CMP0L && idx <= stm_pkg::IDX_CMP2H) begin
                    rd_reg = {1'b0, s.cmp[off[2:1]][{off[0], 3'h0} +: 8]};
                end else begin
                    rd_reg = 9'h100;
                end
            end
        endcase
    endfunction

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        d = q;
        set = '0;
        w1c = '0;
        hard_rst = 1'b0;
        cnt_wr = 1'b0;
        widx = q.awaddr[7:2];
        coff = widx - stm_pkg::IDX_CMP0L;
        rd = 9'h000;
        wr_chk = rd_reg(widx, q);

        // Only the second stage and the edge history are looked at.
        d.ev_s1 = EVENT_IN;
        d.ev_s2 = q.ev_s1;
        d.ev_prev = q.ev_s2;
        ev_rise = q.ev_s2 && !q.ev_prev;
        ev_any = q.ev_s2 != q.ev_prev;
        event_action_field = q.event_control_register[stm_pkg::EVENT_CONTROL_REGISTER_EVENT_ACTION_FIELD_LSB +: 3];
        wg_ss = q.ctrlb[2:0] == stm_pkg::WG_SINGLE_SLOPE_SETTING;

        // The prescaler keeps running in idle sleep; nothing here gates it.
        step = tk.tick;
        down = q.split;
        if (!q.split && q.event_control_register[stm_pkg::EVENT_CONTROL_REGISTER_COUNT_ON_EVENT_ENABLE_BIT]) begin
            case (event_action_field)
                stm_pkg::EVENT_ACTION_FIELD_POSEDGE: step = ev_rise;
                stm_pkg::EVENT_ACTION_FIELD_ANYEDGE: step = ev_any;
                stm_pkg::EVENT_ACTION_FIELD_HIGH: step = tk.tick && q.ev_s2;
                stm_pkg::EVENT_ACTION_FIELD_UPDOWN: down = q.ev_s2;
                default: step = tk.tick;
            endcase
        end
        step = step && q.en;

        if (step && q.split) begin
            for (int i = 0; i < 3; i++) begin
                if (q.cnt[7:0] == q.cmp[i][7:0]) begin
                    set[stm_pkg::FLG_COMPARE_CHANNEL_ZERO + i] = 1'b1;
                    d.wo[i] = 1'b1;
                end
                // High-byte matches only drive the waveform, never a flag.
                if (q.cnt[15:8] == q.cmp[i][15:8]) begin
                    d.wo[i + 3] = 1'b1;
                end
            end
            if (q.cnt[7:0] == 8'h00) begin
                d.cnt[7:0] = q.per[7:0];
                set[stm_pkg::FLG_OVF] = 1'b1;
                d.wo[2:0] = 3'h0;
            end else begin
                d.cnt[7:0] = q.cnt[7:0] - 8'h01;
            end
            if (q.cnt[15:8] == 8'h00) begin
                d.cnt[15:8] = q.per[15:8];
                set[stm_pkg::FLG_HIGH_UNDERFLOW_SOURCE] = 1'b1;
                d.wo[5:3] = 3'h0;
            end else begin
                d.cnt[15:8] = q.cnt[15:8] - 8'h01;
            end
        end else if (step) begin
            for (int i = 0; i < 3; i++) begin
                if (q.cnt == q.cmp[i]) begin
                    set[stm_pkg::FLG_COMPARE_CHANNEL_ZERO + i] = 1'b1;
                    d.wo[i] = 1'b0;
                end
            end
            d.wo[5:3] = 3'h0;
            if (down && q.cnt == 16'h0000) begin
                d.cnt = q.per;
                set[stm_pkg::FLG_OVF] = 1'b1;
                d.wo[2:0] = 3'h7;
            end else if (down) begin
                d.cnt = q.cnt - 16'h0001;
            end else if (q.cnt == q.per) begin
                d.cnt = 16'h0000;
                set[stm_pkg::FLG_OVF] = 1'b1;
                d.wo[2:0] = 3'h7;
            end else begin
                d.cnt = q.cnt + 16'h0001;
            end
        end

        // ********************************************************
        // Register bus
        // ********************************************************
        if (q.bvalid && S_AXI_BREADY) begin
            d.bvalid = 1'b0;
        end
        if (q.awready && S_AXI_AWVALID) begin
            d.aw_have = 1'b1;
            d.awaddr = S_AXI_AWADDR;
        end
        if (q.wready && S_AXI_WVALID) begin
            d.w_have = 1'b1;
            d.wdata = S_AXI_WDATA[7:0];
            d.wstrb0 = S_AXI_WSTRB[0];
        end
        // Every register is one byte wide in the low lane; no temporary
        // pairing exists, and no buffer registers are mapped.
        if (q.aw_have && q.w_have && !q.bvalid) begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = wr_chk[8] ? stm_pkg::RESP_SLVERR : stm_pkg::RESP_OKAY;
            if (q.wstrb0) begin
                case (widx)
                    stm_pkg::IDX_CONTROL_A_REGISTER: begin
                        d.en = q.wdata[stm_pkg::CONTROL_A_REGISTER_EN_BIT];
                        d.clock_select_field = q.wdata[stm_pkg::CONTROL_A_REGISTER_CLOCK_SELECT_FIELD_LSB +: 3];
                    end
                    stm_pkg::IDX_CTRLB: d.ctrlb = q.wdata[6:0];
                    // Other fields are only reinterpreted, never rewritten.
                    stm_pkg::IDX_CONTROL_D_REGISTER: d.split = q.wdata[stm_pkg::CONTROL_D_REGISTER_SPLIT_BIT];
                    stm_pkg::IDX_CONTROL_E_SET_REGISTER: begin
                        hard_rst = q.wdata[stm_pkg::CTRLE_CMD_LSB +: 2] == stm_pkg::CMD_RESET
                            && !q.en;
                    end
                    stm_pkg::IDX_EVENT_CONTROL_REGISTER: d.event_control_register = q.wdata[3:0];
                    stm_pkg::IDX_INTERRUPT_ENABLE_REGISTER: d.inten = q.wdata[6:0];
                    stm_pkg::IDX_INTERRUPT_FLAG_REGISTER: w1c = q.wdata[6:0];
                    stm_pkg::IDX_CNTL: begin
                        d.cnt[7:0] = q.wdata;
                        cnt_wr = 1'b1;
                    end
                    stm_pkg::IDX_CNTH: begin
                        d.cnt[15:8] = q.wdata;
                        cnt_wr = 1'b1;
                    end
                    stm_pkg::IDX_PERL: d.per[7:0] = q.wdata;
                    stm_pkg::IDX_PERH: d.per[15:8] = q.wdata;
                    default: begin
                        if (widx >= stm_pkg::IDX_CMP0L && widx <= stm_pkg::IDX_CMP2H) begin
                            d.cmp[coff[2:1]][{coff[0], 3'h0} +: 8] = q.wdata;
                        end
                    end
                endcase
            end
        end
        if (q.rvalid && S_AXI_RREADY) begin
            d.rvalid = 1'b0;
        end
        if (q.arready && S_AXI_ARVALID) begin
            rd = rd_reg(S_AXI_ARADDR[7:2], q);
            d.rvalid = 1'b1;
            d.rdata = rd[7:0];
            d.rresp = rd[8] ? stm_pkg::RESP_SLVERR : stm_pkg::RESP_OKAY;
        end

        // A flag set in the same cycle as its clear survives.
        d.flags = (q.flags & ~w1c) | set;
        d.ev = {set[6:4], set[stm_pkg::FLG_HIGH_UNDERFLOW_SOURCE], set[stm_pkg::FLG_OVF]};

        if (hard_rst) begin
            d.clock_select_field = '0;
            d.ctrlb = '0;
            d.split = 1'b0;
            d.event_control_register = '0;
            d.inten = '0;
            d.flags = '0;
            d.cnt = '0;
            d.per = stm_pkg::PER_RESET;
            d.cmp = '0;
            d.wo = '0;
        end

        // Non-PWM modes leave the pins low; only single slope drives them.
        d.pin = wg_ss ? d.wo & {q.ctrlb[stm_pkg::CTRLB_CMPEN_LSB +: 3],
                                q.ctrlb[stm_pkg::CTRLB_CMPEN_LSB +: 3]} : 6'h00;
        d.irq = |(d.flags & d.inten);
        d.awready = !d.aw_have && !d.bvalid;
        d.wready = !d.w_have && !d.bvalid;
        d.arready = !d.rvalid;
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            q <= '0;
            q.per <= stm_pkg::PER_RESET;
        end else begin
            q <= d;
        end
    end

    assign tk.run = q.en;
    assign tk.sel = q.clock_select_field;

    stm_prescaler u_presc (
        .clk(MCLK),
        .rst_n(RESETN),
        .tk(tk)
    );

    // ************************************************************
    // Outputs
    // ************************************************************
    assign S_AXI_AWREADY = q.awready;
    assign S_AXI_WREADY = q.wready;
    assign S_AXI_BVALID = q.bvalid;
    assign S_AXI_BRESP = q.bresp;
    assign S_AXI_ARREADY = q.arready;
    assign S_AXI_RVALID = q.rvalid;
    assign S_AXI_RRESP = q.rresp;
    assign S_AXI_RDATA = {24'h000000, q.rdata};
    assign EV_OVERFLOW_LOW_UNDERFLOW_EVENT = q.ev[0];
    assign EV_HIGH_UNDERFLOW_SOURCE = q.ev[1];
    assign EV_CMP = q.ev[4:2];
    assign WO = q.pin;
    assign IRQ = q.irq;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RESETN);

    a_event_flag_pair: assert property (q.ev[0] |-> q.flags[stm_pkg::FLG_OVF])
        else $error("overflow event without its flag");
    a_high_underflow_source_split_only: assert property (q.ev[1] |-> $past(q.split))
        else $error("high underflow event outside split mode");
    a_irq_follows: assert property (q.irq == |(q.flags & q.inten))
        else $error("interrupt request disagrees with flags and enables");
    a_flag_sticky: assert property (q.flags[0] && !w1c[0] && !hard_rst |=> q.flags[0])
        else $error("flag dropped without a clear");
    a_low_cmp_cause: assert property ($rose(q.flags[4]) && $past(q.split)
        |-> $past(q.cnt[7:0]) == $past(q.cmp[0][7:0]))
        else $error("split compare flag without a low-byte match");
    a_reset_guard: assert property (hard_rst |-> !q.en ##1 q.per == stm_pkg::PER_RESET)
        else $error("hard reset taken while enabled or incomplete");
    a_low_reload: assert property (step && q.split && q.cnt[7:0] == 8'h00 && !cnt_wr
        |=> q.cnt[7:0] == $past(q.per[7:0]))
        else $error("low counter did not reload from its period byte");
    a_split_down: assert property (step && q.split && q.cnt[7:0] != 8'h00 && !cnt_wr
        && !hard_rst |=> q.cnt[7:0] == $past(q.cnt[7:0]) - 8'h01)
        else $error("low counter did not count down");
    a_wave_clear: assert property (step && q.split && q.cnt[7:0] == 8'h00 && !hard_rst
        |=> !q.wo[0])
        else $error("split waveform not cleared at bottom");

endmodule

// >>> dv/stm_ev_partner.sv
`timescale 1ns/1ps
// ************************************************************
// Event network and interrupt controller beside the timer
// ************************************************************
module stm_ev_partner (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Event pulses and interrupt from the timer
    input wire logic ev_ovf,
    input wire logic ev_high_underflow_source,
    input wire logic [2:0] ev_cmp,
    input wire logic irq,
    // Event towards the timer
    output logic event_out
);
    int n_ovf = 0;
    int n_high_underflow_source = 0;
    int n_cmp [3] = '{0, 0, 0};
    int n_long = 0;
    int n_irq = 0;
    logic [4:0] prev = 5'h00;

    initial event_out = 1'b0;

    // A pulse still high on the following edge is counted as too long.
    always @(posedge clk) begin
        if (rst_n) begin
            n_ovf <= n_ovf + int'(ev_ovf);
            n_high_underflow_source <= n_high_underflow_source + int'(ev_high_underflow_source);
            for (int i = 0; i < 3; i++) begin
                n_cmp[i] <= n_cmp[i] + int'(ev_cmp[i]);
            end
            n_irq <= n_irq + int'(irq);
            if (|({ev_ovf, ev_high_underflow_source, ev_cmp} & prev)) begin
                n_long <= n_long + 1;
            end
        end
        prev <= {ev_ovf, ev_high_underflow_source, ev_cmp};
    end

    // Edges are kept several cycles apart, well below the counting rate.
    task automatic send_edges(input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            event_out <= ~event_out;
            repeat (gap) @(posedge clk);
        end
    endtask
endmodule

// >>> dv/tb_split_timer_events_irq.sv
`timescale 1ns/1ps
module tb_split_timer_events_irq;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, ev_ovf, ev_high_underflow_source, irq, event_in;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rd;
    logic [2:0] ev_cmp;
    logic [5:0] wo;
    int mismatches = 0;
    int samples_checked = 0;
    logic wo0_high = 1'b0;
    logic wo1_high = 1'b0;

    always #12.5 mclk = ~mclk;

    // Sticky record of waveform pins 0 and 1, so a short pulse is not missed.
    always @(posedge mclk) begin
        if (wo[0] === 1'b1) wo0_high <= 1'b1;
        if (wo[1] === 1'b1) wo1_high <= 1'b1;
    end

    stm_top stm_top_i (.MCLK(mclk), .RESETN(resetn),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .EVENT_IN(event_in), .EV_OVERFLOW_LOW_UNDERFLOW_EVENT(ev_ovf), .EV_HIGH_UNDERFLOW_SOURCE(ev_high_underflow_source), .EV_CMP(ev_cmp),
        .WO(wo), .IRQ(irq));

    stm_ev_partner stm_ev_partner_i (.clk(mclk), .rst_n(resetn), .ev_ovf(ev_ovf),
        .ev_high_underflow_source(ev_high_underflow_source), .ev_cmp(ev_cmp), .irq(irq), .event_out(event_in));

    // ************************************************************
    // Bus tasks and comparison
    // ************************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Handshakes are judged at the falling edge, where the slave outputs are settled.
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic aw_t, w_t, b_t;
        @(posedge mclk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 200; n++) begin
            @(negedge mclk);
            aw_t = awvalid && awready;
            w_t = wvalid && wready;
            b_t = bvalid;
            rs = bresp;
            @(posedge mclk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
            if (b_t) begin
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rdr(input logic [5:0] idx);
        logic ar_t, r_t;
        @(posedge mclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 200; n++) begin
            @(negedge mclk);
            ar_t = arvalid && arready;
            r_t = rvalid;
            rd = rdata;
            rs = rresp;
            @(posedge mclk);
            if (ar_t) arvalid <= 1'b0;
            if (r_t) begin
                rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rdc(input logic [5:0] idx, input logic [31:0] exp, input string what);
        rdr(idx);
        chk(what, exp, rd);
    endtask

    task close_out;
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        close_out;
    end

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        repeat (2) @(posedge mclk);
        rdc(stm_pkg::IDX_PERL, 32'h000000ff, "period low reset");
        rdc(stm_pkg::IDX_CONTROL_A_REGISTER, 32'h00000000, "control a reset");
        rdr(6'h3f);
        chk("unmapped read resp", {30'h0, stm_pkg::RESP_SLVERR}, {30'h0, rs});
        wr(6'h3f, 8'h5a);
        chk("unmapped write resp", {30'h0, stm_pkg::RESP_SLVERR}, {30'h0, rs});
        wr(stm_pkg::IDX_EVENT_CONTROL_REGISTER, {4'h0, stm_pkg::EVENT_ACTION_FIELD_POSEDGE, 1'b1});
        wr(stm_pkg::IDX_CONTROL_A_REGISTER, 8'h01);
        stm_ev_partner_i.send_edges(6, 6);
        repeat (6) @(posedge mclk);
        rdc(stm_pkg::IDX_CNTL, 32'h00000003, "count on rising edges");
        wr(stm_pkg::IDX_EVENT_CONTROL_REGISTER, {4'h0, stm_pkg::EVENT_ACTION_FIELD_ANYEDGE, 1'b1});
        stm_ev_partner_i.send_edges(4, 6);
        repeat (6) @(posedge mclk);
        rdc(stm_pkg::IDX_CNTL, 32'h00000007, "count on any edge");
        chk("high underflow in normal", 0, 32'(stm_ev_partner_i.n_high_underflow_source));
        wr(stm_pkg::IDX_CONTROL_A_REGISTER, 8'h00);
        wr(stm_pkg::IDX_CONTROL_E_SET_REGISTER, 8'h0c);
        rdc(stm_pkg::IDX_EVENT_CONTROL_REGISTER, 32'h00000000, "event control after reset");
        wr(stm_pkg::IDX_CONTROL_D_REGISTER, 8'h01);
        rdc(stm_pkg::IDX_PERL, 32'h000000ff, "period kept over mode change");
        wr(stm_pkg::IDX_PERL, 8'h03);
        wr(stm_pkg::IDX_PERH, 8'h02);
        wr(stm_pkg::IDX_CMP0L, 8'h01);
        wr(stm_pkg::IDX_INTERRUPT_ENABLE_REGISTER, 8'h13);
        wr(stm_pkg::IDX_CTRLB, 8'h13);
        wr(stm_pkg::IDX_CONTROL_A_REGISTER, 8'h01);
        repeat (40) @(posedge mclk);
        wr(stm_pkg::IDX_CONTROL_A_REGISTER, 8'h00);
        chk("long event pulses", 0, 32'(stm_ev_partner_i.n_long));
        chk("low underflow events", 1, 32'(stm_ev_partner_i.n_ovf > 0));
        chk("high underflow events", 1, 32'(stm_ev_partner_i.n_high_underflow_source > 0));
        chk("compare 0 events", 1, 32'(stm_ev_partner_i.n_cmp[0] > 0));
        chk("enabled waveform pin toggled", 1, {31'h0, wo0_high});
        chk("disabled waveform pin low", 0, {31'h0, wo1_high});
        rdc(stm_pkg::IDX_INTERRUPT_FLAG_REGISTER, 32'h00000073, "split flags");
        chk("request while flagged", 1, {31'h0, irq});
        wr(stm_pkg::IDX_INTERRUPT_FLAG_REGISTER, 8'h13);
        repeat (2) @(posedge mclk);
        chk("request after clear", 0, {31'h0, irq});
        rdc(stm_pkg::IDX_INTERRUPT_FLAG_REGISTER, 32'h00000060, "flags after clear");
        rdr(stm_pkg::IDX_CNTL);
        chk("low counter within period", 1, 32'(rd <= 32'h3));
        rdr(stm_pkg::IDX_CNTH);
        chk("high counter within period", 1, 32'(rd <= 32'h2));
        close_out;
    end
endmodule
